//--- common/dwa_pkg.sv
// Shared constants and carrier types for the drum word/address control.
// Assumes a single 125 MHz clock; used by every design file by scope.
package dwa_pkg;
    localparam int DATA_W = 30;
    localparam int ADDR_W = 22;
    localparam int OP_W = 6;
    localparam int OP_LSB = 24;
    localparam int ANG_W = 11;
    localparam int BAND_W = 7;
    localparam int DRUM_W = 4;
    localparam int TRACK_BITS = 12;
    localparam int SLOT_BITS = 14;
    localparam int BANDS_PER_DRUM = 128;
    localparam int WORDS_PER_BAND = 2048;
    localparam int GAP_WORDS = 48;
    localparam logic [DRUM_W-1:0] MAX_DRUM = 4'h8;
    localparam logic [DRUM_W-1:0] INST_RST = 4'h3;
    localparam logic [5:0] PAD_ONES = 6'h3f;

    // Operation codes carried in the six top bits of a function word.
    localparam logic [OP_W-1:0] OP_WRITE = 6'h02;
    localparam logic [OP_W-1:0] OP_TERM_QUIET = 6'h13;
    localparam logic [OP_W-1:0] OP_TERM_INT = 6'h1b;

    // Status codes; the parity code matches the processor convention.
    localparam logic [OP_W-1:0] STS_TERM = 6'h00;
    localparam logic [OP_W-1:0] STS_ILLEGAL = 6'h01;
    localparam logic [OP_W-1:0] STS_END_FILE = 6'h02;
    localparam logic [OP_W-1:0] STS_FAULT = 6'h03;
    localparam logic [OP_W-1:0] STS_PARITY = 6'h34;

    // One drum revolution, and its length in 8 ns clock cycles.
    localparam longint REV_NS = 8430000;
    localparam longint CLK_NS = 8;
    localparam int REV_CYCLES = int'(REV_NS / CLK_NS);

    typedef struct packed {
        logic [DRUM_W-1:0] drum;
        logic [BAND_W-1:0] band;
        logic [ANG_W-1:0] ang;
    } dwa_addr_t;

    // Each slot: guard at bit 13, parity at bit 12, data in 11:0.
    typedef struct packed {
        logic [SLOT_BITS-1:0] t2;
        logic [SLOT_BITS-1:0] t1;
        logic [SLOT_BITS-1:0] t0;
    } dwa_tracks_t;

    typedef struct packed {
        logic fault;
        logic tick;
        logic [ANG_W-1:0] ang;
        dwa_tracks_t rd;
    } dwa_drum_in_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH,
        S_SEEK,
        S_OFFER
    } dwa_state_t;
endpackage

//--- rtl/dwa_track_codec.sv
// Splits a 30-bit word over three track slots and merges it back.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/1ps
`default_nettype none
module dwa_track_codec (
    input wire logic [29:0] wr_word,
    output dwa_pkg::dwa_tracks_t wr_tracks,
    input wire dwa_pkg::dwa_tracks_t rd_tracks,
    output logic [29:0] rd_word,
    output logic rd_par_err
);
    function automatic logic odd_par(input logic [11:0] d);
        return ~^d;
    endfunction

    function automatic logic slot_bad(input logic [13:0] s);
        return ~^s[12:0];
    endfunction

    logic [11:0] pad_seg;

    // The six spare positions of the third track are recorded as ones.
    assign pad_seg = {dwa_pkg::PAD_ONES, wr_word[29:24]}; // R3

    // Parity covers the whole 12-position segment, padding included.
    always_comb begin
        wr_tracks.t0 = {1'b0, odd_par(wr_word[11:0]), wr_word[11:0]}; // R2
        wr_tracks.t1 = {1'b0, odd_par(wr_word[23:12]), wr_word[23:12]};
        wr_tracks.t2 = {1'b0, odd_par(pad_seg), pad_seg}; // R4 R20 R22
    end

    assign rd_word = {rd_tracks.t2[5:0], rd_tracks.t1[11:0],
        rd_tracks.t0[11:0]}; // R5
    assign rd_par_err = slot_bad(rd_tracks.t0) | slot_bad(rd_tracks.t1) |
        slot_bad(rd_tracks.t2); // R20
endmodule
`default_nettype wire

//--- rtl/dwa_ctrl.sv
// Drum control: function decode, address sequencing, word transfer.
// Assumes a processor channel on the same clock and asynchronous drum pins.
//
// Function
// R1 - Each drum holds 128 bands of three tracks, 2048 words per band.
// R2 - Bits 0-11, 12-23, 24-29 go to tracks one, two, three.
// R3 - A word fills 36 positions; six spare third-track positions are ones.
// R4 - Each track segment gets a parity bit then a guard position.
// R5 - Reads take three segments, check parity, merge into 30 bits.
// R6 - Address: drum in 21:18, band in 17:11, angle in 10:0.
// R7 - Valid drum 0-8, band 0-127, angle 0-2047.
// R8 - Start address is the low 22 bits of the function word.
// R9 - Select heads, start only when timing angle equals target angle.
// R10 - Increment after each word, carrying angle to band to drum.
// R11 - The 48-word dead gap covers head switching at band end.
// R12 - Out-of-configuration address stops with interrupt and status.
// R13 - Separate 30-bit in and out paths, each with request and acknowledge.
// R14 - A function word starts the operation, then it runs alone.
// R15 - The processor acknowledges every request on the matching path.
// R16 - On a late acknowledge stay active and wait further revolutions.
// R17 - Stay active until terminate or an interrupting condition.
// R18 - Interrupt with status for normal and abnormal events.
// R19 - Processor terminates functions that do not end by themselves.
// R20 - Parity is odd, generated and checked per track segment.
// R21 - The operation code is the six top bits of the function word.
// R22 - Parity spans all 12 positions including padding.
`timescale 1ns/1ps
`default_nettype none
module dwa_ctrl #(
    parameter int REV_CYCLES = dwa_pkg::REV_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] inst_drums,
    input wire logic func_valid,
    input wire logic [29:0] func_word,
    output logic out_req,
    input wire logic out_ack,
    input wire logic [29:0] out_data,
    output logic in_req,
    input wire logic in_ack,
    output logic [29:0] in_data,
    output logic ext_int,
    output logic [29:0] status_word,
    output logic busy,
    output logic [3:0] head_drum,
    output logic [6:0] head_band,
    output logic head_wr_en,
    output dwa_pkg::dwa_tracks_t head_wr,
    input wire logic drum_tick,
    input wire logic [10:0] drum_ang,
    input wire dwa_pkg::dwa_tracks_t drum_rd,
    input wire logic drum_fault
);
    localparam logic [21:0] SEEK_LIMIT = 22'(2 * REV_CYCLES);

    // The plain +1 carries angle into band into drum since the fields fill
    // their widths exactly: 2047 -> 0 steps the band, band 127 the drum.
    function automatic dwa_pkg::dwa_addr_t addr_inc(
        input dwa_pkg::dwa_addr_t a);
        return dwa_pkg::dwa_addr_t'(a + 22'h000001); // R10 R1
    endfunction

    function automatic logic addr_ok(input dwa_pkg::dwa_addr_t a,
        input logic [3:0] inst);
        return (a.drum <= dwa_pkg::MAX_DRUM) && (a.drum < inst); // R7 R12
    endfunction

    dwa_pkg::dwa_drum_in_t pin_in;
    dwa_pkg::dwa_drum_in_t s1_ff, s2_ff, s3_ff, stab_ff;
    logic tick_prev_ff;
    dwa_pkg::dwa_state_t state_ff;
    dwa_pkg::dwa_addr_t addr_ff;
    logic wr_mode_ff;
    logic [29:0] word_ff;
    logic [29:0] in_data_ff;
    logic in_req_ff, out_req_ff;
    logic head_wr_en_ff;
    dwa_pkg::dwa_tracks_t head_wr_ff;
    logic ext_int_ff;
    logic [29:0] status_ff;
    logic [21:0] seek_cnt_ff;
    logic [3:0] inst_ff;

    logic word_pulse, match, term_cmd, start_cmd, start_ok, timeout;
    logic fault_now, wr_done, rd_good, rd_bad, in_take, out_take;
    logic inc_ok;
    logic [5:0] op;
    dwa_pkg::dwa_addr_t start_addr, inc_addr;
    dwa_pkg::dwa_tracks_t enc_tracks;
    logic [29:0] dec_word;
    logic dec_err;

    assign pin_in = '{fault: drum_fault, tick: drum_tick, ang: drum_ang,
        rd: drum_rd};

    // The installed drum count is a strap, caught while reset is held.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            inst_ff <= inst_drums;
        end
    end

    // Drum pins are asynchronous: a change is taken once stages 2 and 3
    // agree, so a skewed multi-bit angle is never seen half updated.
    always_ff @(posedge clock) begin
        s1_ff <= pin_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (sys_rst) begin
            stab_ff <= '0;
            tick_prev_ff <= 1'b0;
        end else begin
            if (s2_ff == s3_ff) begin
                stab_ff <= s3_ff;
            end
            tick_prev_ff <= stab_ff.tick;
        end
    end

    dwa_track_codec u_codec (
        .wr_word(word_ff),
        .wr_tracks(enc_tracks),
        .rd_tracks(stab_ff.rd),
        .rd_word(dec_word),
        .rd_par_err(dec_err)
    );

    always_comb begin
        op = func_word[29:24]; // R21
        start_addr = dwa_pkg::dwa_addr_t'(func_word[21:0]); // R8 R6
        term_cmd = func_valid && (op == dwa_pkg::OP_TERM_QUIET ||
            op == dwa_pkg::OP_TERM_INT);
        start_cmd = func_valid && !term_cmd &&
            state_ff == dwa_pkg::S_IDLE; // R14
        start_ok = start_cmd && addr_ok(start_addr, inst_ff);
        word_pulse = stab_ff.tick && !tick_prev_ff;
        fault_now = stab_ff.fault && state_ff != dwa_pkg::S_IDLE;
        match = state_ff == dwa_pkg::S_SEEK && word_pulse &&
            stab_ff.ang == addr_ff.ang; // R9
        timeout = state_ff == dwa_pkg::S_SEEK && seek_cnt_ff == SEEK_LIMIT;
        wr_done = match && wr_mode_ff;
        rd_good = match && !wr_mode_ff && !dec_err;
        rd_bad = match && !wr_mode_ff && dec_err; // R5
        in_take = in_req_ff && in_ack;
        out_take = out_req_ff && out_ack;
        inc_addr = addr_inc(addr_ff);
        inc_ok = addr_ok(inc_addr, inst_ff);
    end

    // Terminate wins over everything; faults next; then normal flow.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= dwa_pkg::S_IDLE;
        end else if (term_cmd || fault_now || timeout) begin
            state_ff <= dwa_pkg::S_IDLE; // R17
        end else begin
            unique case (state_ff)
                dwa_pkg::S_IDLE: begin
                    if (start_ok) begin
                        state_ff <= (op == dwa_pkg::OP_WRITE) ?
                            dwa_pkg::S_FETCH : dwa_pkg::S_SEEK;
                    end
                end
                dwa_pkg::S_FETCH: begin
                    if (out_take) begin
                        state_ff <= dwa_pkg::S_SEEK;
                    end
                end
                dwa_pkg::S_SEEK: begin
                    if (rd_bad || (wr_done && !inc_ok)) begin
                        state_ff <= dwa_pkg::S_IDLE; // R12 R18
                    end else if (wr_done) begin
                        state_ff <= dwa_pkg::S_FETCH;
                    end else if (rd_good) begin
                        state_ff <= dwa_pkg::S_OFFER;
                    end
                end
                dwa_pkg::S_OFFER: begin
                    // A late acknowledge just costs revolutions in seek.
                    if (in_take) begin
                        state_ff <= inc_ok ? dwa_pkg::S_SEEK :
                            dwa_pkg::S_IDLE; // R16 R12
                    end
                end
            endcase
        end
    end

    // Heads follow addr_ff at once, so a band change settles in the gap.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_ff <= '0;
            wr_mode_ff <= 1'b0;
        end else if (start_ok) begin
            addr_ff <= start_addr; // R8
            wr_mode_ff <= (op == dwa_pkg::OP_WRITE);
        end else if (!term_cmd && (wr_done || in_take) && inc_ok) begin
            addr_ff <= inc_addr; // R10 R11
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || state_ff != dwa_pkg::S_SEEK) begin
            seek_cnt_ff <= '0;
        end else begin
            seek_cnt_ff <= seek_cnt_ff + 22'h000001; // R16
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_req_ff <= 1'b0;
            in_req_ff <= 1'b0;
            word_ff <= '0;
            in_data_ff <= '0;
        end else begin
            out_req_ff <= !term_cmd && !fault_now && (
                (start_ok && op == dwa_pkg::OP_WRITE) ||
                (wr_done && inc_ok) ||
                (out_req_ff && !out_ack)); // R13
            in_req_ff <= !term_cmd && !fault_now &&
                (rd_good || (in_req_ff && !in_ack)); // R13 R16
            if (out_take) begin
                word_ff <= out_data;
            end
            if (match && !wr_mode_ff) begin
                in_data_ff <= dec_word; // R5
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            head_wr_en_ff <= 1'b0;
            head_wr_ff <= '0;
        end else begin
            head_wr_en_ff <= wr_done && !term_cmd && !fault_now;
            if (wr_done) begin
                head_wr_ff <= enc_tracks; // R2 R3 R4
            end
        end
    end

    // Status carries the code on top and the address involved below.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_int_ff <= 1'b0;
            status_ff <= '0;
        end else begin
            ext_int_ff <= 1'b1;
            if (func_valid && op == dwa_pkg::OP_TERM_INT) begin
                status_ff <= {dwa_pkg::STS_TERM, 2'h0, addr_ff};
            end else if (term_cmd) begin
                ext_int_ff <= 1'b0;
            end else if (fault_now || timeout) begin
                status_ff <= {dwa_pkg::STS_FAULT, 2'h0, addr_ff}; // R18
            end else if (start_cmd && !start_ok) begin
                status_ff <= {dwa_pkg::STS_ILLEGAL, 2'h0, start_addr}; // R12
            end else if (rd_bad) begin
                status_ff <= {dwa_pkg::STS_PARITY, 2'h0, addr_ff}; // R18
            end else if ((wr_done || in_take) && !inc_ok) begin
                status_ff <= {dwa_pkg::STS_END_FILE, 2'h0, inc_addr}; // R12
            end else begin
                ext_int_ff <= 1'b0;
            end
        end
    end

    assign out_req = out_req_ff;
    assign in_req = in_req_ff;
    assign in_data = in_data_ff;
    assign ext_int = ext_int_ff;
    assign status_word = status_ff;
    assign busy = state_ff != dwa_pkg::S_IDLE;
    assign head_drum = addr_ff.drum;
    assign head_band = addr_ff.band;
    assign head_wr_en = head_wr_en_ff;
    assign head_wr = head_wr_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_WR_MAP: assert property (head_wr_en_ff |-> // R2
        head_wr_ff.t0[11:0] == $past(word_ff[11:0]) &&
        head_wr_ff.t1[11:0] == $past(word_ff[23:12]) &&
        head_wr_ff.t2[5:0] == $past(word_ff[29:24]))
        else $error("track split wrong");
    AST_PAD: assert property (head_wr_en_ff |-> // R3
        head_wr_ff.t2[11:6] == dwa_pkg::PAD_ONES)
        else $error("padding not ones");
    AST_PARITY: assert property (head_wr_en_ff |-> // R4
        (^head_wr_ff.t0[12:0]) && (^head_wr_ff.t1[12:0]) &&
        (^head_wr_ff.t2[12:0]) && !head_wr_ff.t0[13] &&
        !head_wr_ff.t1[13] && !head_wr_ff.t2[13])
        else $error("slot parity or guard wrong");
    AST_START_ADDR: assert property (start_ok |=> // R8
        addr_ff == $past(func_word[21:0]) && busy)
        else $error("start address not taken");
    AST_MATCH_ONLY: assert property ($rose(head_wr_en_ff) |-> // R9
        $past(word_pulse) && $past(stab_ff.ang) == $past(addr_ff.ang))
        else $error("write without angle match");
    AST_INCR: assert property (in_take && inc_ok && !term_cmd && // R10
        !fault_now |=> addr_ff == addr_inc($past(addr_ff)) &&
        state_ff == dwa_pkg::S_SEEK)
        else $error("address not incremented");
    AST_ILLEGAL: assert property (start_cmd && !start_ok |=> // R12
        ext_int_ff && status_ff[29:24] == dwa_pkg::STS_ILLEGAL && !busy)
        else $error("illegal start not reported");
    AST_READ_MERGE: assert property ($rose(in_req_ff) |-> // R5
        in_data_ff == $past(dec_word))
        else $error("read word not merged");
    AST_LATE_ACK: assert property (in_req_ff && !in_ack && !term_cmd && // R16
        !fault_now |=> in_req_ff [*1] ##0 busy)
        else $error("request dropped before ack");
    AST_ACTIVE: assert property ($fell(busy) |-> // R17
        ext_int_ff || $past(term_cmd))
        else $error("went idle silently");
    AST_PAR_INT: assert property (rd_bad && !term_cmd && !fault_now && // R18
        !timeout |=> ext_int_ff && status_ff[29:24] == dwa_pkg::STS_PARITY)
        else $error("parity error not reported");
    AST_OUT_HOLD: assert property (out_req_ff && !out_ack && // R13
        !term_cmd && !fault_now |=> out_req_ff)
        else $error("output request dropped");

    COV_WRITE: cover property (head_wr_en_ff ##[1:20] out_req_ff);
    COV_READ: cover property (in_take ##[1:20] in_req_ff);
    COV_BAND: cover property (in_take && addr_ff.ang == 11'h7ff);
    COV_TERM: cover property (busy ##1 term_cmd);
endmodule
`default_nettype wire

//--- bench/dwa_proc_model.sv
// Processor channel model that answers the device's data requests.
// Assumes the device clock; it drives 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dwa_proc_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic out_req,
    output logic out_ack,
    output logic [29:0] out_data,
    input wire logic in_req,
    output logic in_ack,
    input wire logic [29:0] in_data,
    input wire logic [29:0] tx_word,
    input wire logic [15:0] delay,
    output logic [29:0] rx_word,
    output logic [15:0] rx_count
);
    logic hold;
    logic [15:0] wait_cnt;
    initial begin
        out_ack = 1'b0;
        in_ack = 1'b0;
        out_data = 30'h0;
        hold = 1'b0;
        wait_cnt = 16'h0;
        rx_word = 30'h0;
        rx_count = 16'h0;
    end
    // Data is valid only beside its acknowledge; otherwise the inverse shows.
    // Hold keeps one request from being answered twice before it drops.
    always @(posedge clock) begin
        #1;
        out_ack = 1'b0;
        in_ack = 1'b0;
        out_data = ~tx_word;
        if (sys_rst) begin
            hold = 1'b0;
            wait_cnt = 16'h0;
        end else if (hold) begin
            hold = out_req | in_req;
        end else if (out_req | in_req) begin
            if (wait_cnt >= delay) begin
                out_ack = out_req;
                in_ack = in_req;
                if (out_req) begin
                    out_data = tx_word;
                end
                if (in_req) begin
                    rx_word = in_data;
                    rx_count = rx_count + 16'h1;
                end
                hold = 1'b1;
                wait_cnt = 16'h0;
            end else begin
                wait_cnt = wait_cnt + 16'h1;
            end
        end else begin
            wait_cnt = 16'h0;
        end
    end
endmodule
`default_nettype wire

//--- bench/dwa_ctrl_tb.sv
// Self-checking bench for dwa_ctrl: rows of transfers, then edge cases.
// Assumes the processor model beside it; the bench plays the drum pins.
`timescale 1ns/1ps
`default_nettype none
module dwa_ctrl_tb;
    localparam int REV = 200;
    typedef struct packed {
        logic wr;
        logic [21:0] a;
        logic [29:0] w;
        logic [21:0] nxt;
    } dwa_row_t;
    dwa_row_t rows [4] = '{
        '{1'b1, 22'h000000, 30'h3fffffff, 22'h000001},
        '{1'b1, 22'h042fff, 30'h12345678, 22'h043000},
        '{1'b0, 22'h07ffff, 30'h2aaaaaaa, 22'h080000},
        '{1'b0, 22'h0a0005, 30'h00000000, 22'h0a0006}};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic func_valid = 1'b0;
    logic drum_tick = 1'b0;
    logic drum_fault = 1'b0;
    logic [3:0] inst_drums = 4'h3;
    logic [29:0] func_word = 30'h0;
    logic [29:0] tx_word = 30'h0;
    logic [15:0] delay = 16'h0;
    logic [10:0] drum_ang = 11'h0;
    dwa_pkg::dwa_tracks_t drum_rd = 42'h0;
    logic out_req, out_ack, in_req, in_ack, ext_int, busy, head_wr_en;
    logic [29:0] out_data, in_data, status_word, rx_word;
    logic [3:0] head_drum;
    logic [6:0] head_band;
    logic [15:0] rx_count;
    dwa_pkg::dwa_tracks_t head_wr, last_wr;
    logic [29:0] last_sts;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int int_cnt = 0;
    int wr_cnt = 0;

    dwa_ctrl #(.REV_CYCLES(REV)) u_dwa_ctrl (.clock(clock),
        .sys_rst(sys_rst), .inst_drums(inst_drums),
        .func_valid(func_valid), .func_word(func_word),
        .out_req(out_req), .out_ack(out_ack), .out_data(out_data),
        .in_req(in_req), .in_ack(in_ack), .in_data(in_data),
        .ext_int(ext_int), .status_word(status_word), .busy(busy),
        .head_drum(head_drum), .head_band(head_band),
        .head_wr_en(head_wr_en), .head_wr(head_wr),
        .drum_tick(drum_tick), .drum_ang(drum_ang), .drum_rd(drum_rd),
        .drum_fault(drum_fault));
    dwa_proc_model u_dwa_proc_model (.clock(clock), .sys_rst(sys_rst),
        .out_req(out_req), .out_ack(out_ack), .out_data(out_data),
        .in_req(in_req), .in_ack(in_ack), .in_data(in_data),
        .tx_word(tx_word), .delay(delay), .rx_word(rx_word),
        .rx_count(rx_count));

    always #4 clock = ~clock;

    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Pulses are sampled at the falling edge, where registers have settled.
    always @(negedge clock) begin
        cycles++;
        if (ext_int === 1'b1) begin
            int_cnt++;
            last_sts = status_word;
        end
        if (head_wr_en === 1'b1) begin
            wr_cnt++;
            last_wr = head_wr;
        end
        if (cycles == 30000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [41:0] seen,
                         input logic [41:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [13:0] slot(input logic [11:0] d);
        return {1'b0, ~^d, d};
    endfunction

    function automatic dwa_pkg::dwa_tracks_t enc(input logic [29:0] w);
        return {slot({6'h3f, w[29:24]}), slot(w[23:12]),
            slot(w[11:0])};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic send_func(input logic [5:0] op, input logic [21:0] a);
        func_word = {op, 2'b00, a};
        func_valid = 1'b1;
        step(1);
        func_valid = 1'b0;
    endtask

    // One word position passes under the heads, angle and data stable.
    task automatic tick(input logic [10:0] ang, input logic [41:0] rd);
        drum_ang = ang;
        drum_rd = rd;
        step(2);
        drum_tick = 1'b1;
        step(6);
        drum_tick = 1'b0;
        step(6);
    endtask

    task automatic wait_int(input int n0);
        for (int i = 0; i < 900 && int_cnt == n0; i++) step(1);
    endtask

    initial begin
        int c;
        int n;
        dwa_row_t r;
        step(15);
        check("rst", {busy, ext_int, out_req, in_req, head_wr_en}, '0);
        step(1);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = rows[i];
            tx_word = r.w;
            c = wr_cnt;
            n = rx_count;
            send_func(r.wr ? dwa_pkg::OP_WRITE : 6'h22, r.a);
            check("busy", busy, 42'h1);
            check("head", {head_drum, head_band}, r.a[21:11]);
            tick(r.a[10:0] ^ 11'h1, enc(r.w));
            check("early", 42'(wr_cnt + rx_count), 42'(c + n));
            tick(r.a[10:0], enc(r.w));
            if (r.wr) begin
                check("wr", last_wr, enc(r.w));
            end else begin
                check("rd", rx_word, r.w);
            end
            check("next", {head_drum, head_band}, r.nxt[21:11]);
            send_func(dwa_pkg::OP_TERM_QUIET, 22'h0);
            check("idle", busy, 42'h0);
        end
        // Drum 3 is outside a three-drum set, drum 9 outside any set.
        for (int d = 3; d < 10; d += 6) begin
            c = int_cnt;
            send_func(6'h22, {4'(d), 18'h0});
            wait_int(c);
            check("ill", last_sts[29:24], dwa_pkg::STS_ILLEGAL);
        end
        c = int_cnt;
        send_func(6'h22, 22'h0bffff);
        tick(11'h7ff, enc(30'h0));
        wait_int(c);
        check("eof", last_sts, {dwa_pkg::STS_END_FILE, 24'h0c0000});
        check("eofb", busy, 42'h0);
        c = int_cnt;
        n = rx_count;
        send_func(6'h22, 22'h000010);
        tick(11'h010, enc(30'h1) ^ 42'h1000);
        wait_int(c);
        check("par", last_sts[29:24], dwa_pkg::STS_PARITY);
        check("parn", {busy, rx_count}, 42'(n));
        delay = 16'd60;
        n = rx_count;
        send_func(6'h22, 22'h000020);
        tick(11'h020, enc(30'h15555555));
        step(20);
        check("late", {busy, in_req}, 42'h3);
        for (int i = 0; i < 300 && rx_count == n; i++) step(1);
        check("lated", rx_word, 30'h15555555);
        delay = 16'h0;
        send_func(dwa_pkg::OP_TERM_QUIET, 22'h0);
        c = int_cnt;
        send_func(6'h22, 22'h000030);
        drum_fault = 1'b1;
        wait_int(c);
        drum_fault = 1'b0;
        check("flt", last_sts[29:24], dwa_pkg::STS_FAULT);
        // Let the fault level leave the pin synchroniser before restarting.
        step(6);
        // No matching word for two revolutions reads as a drum fault.
        c = int_cnt;
        send_func(6'h22, 22'h000050);
        step(300);
        check("tmob", busy, 42'h1);
        wait_int(c);
        check("tmo", last_sts[29:24], dwa_pkg::STS_FAULT);
        // A slow output acknowledge keeps the request standing meanwhile.
        delay = 16'd5;
        c = int_cnt;
        send_func(dwa_pkg::OP_WRITE, 22'h000040);
        send_func(6'h22, 22'h240000);
        step(3);
        check("ign", {busy, 32'(int_cnt)}, {1'b1, 32'(c)});
        send_func(dwa_pkg::OP_TERM_INT, 22'h0);
        check("term", {ext_int, busy, out_req}, 42'h4);
        check("tsts", status_word[29:24], dwa_pkg::STS_TERM);
        step(4);
        final_report();
    end
endmodule
`default_nettype wire
